// File: core/dvr_bank.v
// Volume and control register bank with staged attenuation latches and soft reset
`timescale 1ns/100ps

module dvr_bank #(
    parameter CHANNELS = 8
) (
    input  wire        CLK_SYS_I,
    input  wire        RST_N_I,
    input  wire        CE_I,
    input  wire        CTRL_WR_I,
    input  wire [15:0] CTRL_WORD_I,
    output wire [7:0]  LEFT_LEVEL_CH1_O,
    output wire [7:0]  RIGHT_LEVEL_CH1_O,
    output wire [7:0]  LEFT_LEVEL_CH2_O,
    output wire [7:0]  RIGHT_LEVEL_CH2_O,
    output wire [7:0]  LEFT_LEVEL_CH3_O,
    output wire [7:0]  RIGHT_LEVEL_CH3_O,
    output wire [7:0]  LEFT_LEVEL_CH4_O,
    output wire [7:0]  RIGHT_LEVEL_CH4_O,
    output wire [7:0]  GLOBAL_LEVEL_O,
    output wire [7:0]  ATTEN_MUTE_O,
    output wire [63:0] ATTEN_HALFDB_O,
    output wire [8:0]  ROUTING_CTRL_O,
    output wire [8:0]  FORMAT_CTRL_O,
    output wire [8:0]  DEEMPH_MUTE_CTRL_O,
    output wire [8:0]  IF_POWER_CTRL_O,
    output wire [8:0]  MUTE_PIN_CTRL_O,
    output wire [8:0]  CH4_CTRL_O,
    output wire        SW_RESET_O
);
`include "dvr_map.vh"

    // ----------------------------------------------------------------
    // Channel address decode
    // ----------------------------------------------------------------
    // Returns {hit, index}; index order is L1 R1 L2 R2 L3 R3 L4 R4
    function [3:0] chan_of;
        input [6:0] adr;
        begin
            case (adr)
                `DVR_LEFT_ATTEN_CH1_ADR:  chan_of = 4'h8;
                `DVR_RIGHT_ATTEN_CH1_ADR: chan_of = 4'h9;
                `DVR_LEFT_ATTEN_CH2_ADR:  chan_of = 4'hA;
                `DVR_RIGHT_ATTEN_CH2_ADR: chan_of = 4'hB;
                `DVR_LEFT_ATTEN_CH3_ADR:  chan_of = 4'hC;
                `DVR_RIGHT_ATTEN_CH3_ADR: chan_of = 4'hD;
                `DVR_LEFT_ATTEN_CH4_ADR:  chan_of = 4'hE;
                `DVR_RIGHT_ATTEN_CH4_ADR: chan_of = 4'hF;
                default:                  chan_of = 4'h0;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    reg [7:0] stage_q   [0:7];
    reg [7:0] applied_q [0:7];
    reg [7:0] stage_d   [0:7];
    reg [7:0] glob_stage_q;
    reg [7:0] glob_applied_q;
    reg [8:0] routing_q;
    reg [8:0] format_q;
    reg [8:0] deemph_q;
    reg [8:0] if_power_q;
    reg [8:0] mute_pin_q;
    reg [8:0] ch4_ctrl_q;
    reg [1:0] swrst_cnt_q;
    reg [1:0] swrst_cnt_d;
    reg       swrst_busy_q;

    wire [6:0] wr_adr;
    wire [8:0] wr_data;
    wire [3:0] chan_sel;
    wire       is_master;
    wire       vol_wr;
    wire       do_update;
    wire       clear_now;
    wire       wr_routing;
    wire       wr_format;
    wire       wr_deemph;
    wire       wr_if_power;
    wire       wr_mute_pin;
    wire       wr_ch4_ctrl;
    integer    i;
    integer    k;

    // ----------------------------------------------------------------
    // Control word split and strobes
    // ----------------------------------------------------------------
    assign wr_adr    = CTRL_WORD_I[`DVR_ADDR_HI:`DVR_ADDR_LO];
    assign wr_data   = CTRL_WORD_I[`DVR_DATA_HI:0];
    assign chan_sel  = chan_of(wr_adr);
    assign is_master = (wr_adr == `DVR_MASTER_ATTEN_ADR);
    assign vol_wr    = CTRL_WR_I & (chan_sel[3] | is_master);
    assign do_update = vol_wr & wr_data[`DVR_UPDATE_BIT];

    // A fresh write to any address but the soft reset one ends the hold, so the host never waits on it
    assign clear_now = CTRL_WR_I ? (wr_adr == `DVR_SOFT_RESET_ADR)
                                 : (swrst_cnt_q != 2'd0);

    // ----------------------------------------------------------------
    // Control register write strobes
    // ----------------------------------------------------------------
    // One strobe per register, so the holes in the map stay inert
    assign wr_routing  = CTRL_WR_I & (wr_adr == `DVR_ROUTING_CTRL_ADR);
    assign wr_format   = CTRL_WR_I & (wr_adr == `DVR_FORMAT_CTRL_ADR);
    assign wr_deemph   = CTRL_WR_I & (wr_adr == `DVR_DEEMPH_MUTE_ADR);
    assign wr_if_power = CTRL_WR_I & (wr_adr == `DVR_IF_POWER_ADR);
    assign wr_mute_pin = CTRL_WR_I & (wr_adr == `DVR_MUTE_PIN_ADR);
    assign wr_ch4_ctrl = CTRL_WR_I & (wr_adr == `DVR_CH4_CTRL_ADR);

    // ----------------------------------------------------------------
    // Next staging values
    // ----------------------------------------------------------------
    // Master write lands in every channel latch, so one update moves all
    always @* begin
        for (i = 0; i < CHANNELS; i = i + 1) begin
            stage_d[i] = stage_q[i];
            if (vol_wr && (is_master || chan_sel[2:0] == i[2:0])) begin
                stage_d[i] = wr_data[`DVR_LEVEL_HI:0];
            end
        end
    end

    // Soft reset hold counter
    always @* begin
        if (CTRL_WR_I) begin
            swrst_cnt_d = (wr_adr == `DVR_SOFT_RESET_ADR) ? `DVR_SWRST_CYCLES : 2'd0;
        end else if (swrst_cnt_q != 2'd0) begin
            swrst_cnt_d = swrst_cnt_q - 2'd1;
        end else begin
            swrst_cnt_d = 2'd0;
        end
    end

    // ----------------------------------------------------------------
    // Attenuation latches
    // ----------------------------------------------------------------
    always @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            for (k = 0; k < CHANNELS; k = k + 1) begin
                stage_q[k]   <= `DVR_LEVEL_RST;
                applied_q[k] <= `DVR_LEVEL_RST;
            end
            glob_stage_q   <= `DVR_LEVEL_RST;
            glob_applied_q <= `DVR_LEVEL_RST;
        end else if (CE_I) begin
            if (clear_now) begin
                for (k = 0; k < CHANNELS; k = k + 1) begin
                    stage_q[k]   <= `DVR_LEVEL_RST;
                    applied_q[k] <= `DVR_LEVEL_RST;
                end
                glob_stage_q   <= `DVR_LEVEL_RST;
                glob_applied_q <= `DVR_LEVEL_RST;
            end else if (vol_wr) begin
                for (k = 0; k < CHANNELS; k = k + 1) begin
                    stage_q[k] <= stage_d[k];
                    if (do_update) begin
                        applied_q[k] <= stage_d[k];
                    end
                end
                if (is_master) begin
                    glob_stage_q <= wr_data[`DVR_LEVEL_HI:0];
                end
                if (do_update) begin
                    glob_applied_q <= is_master ? wr_data[`DVR_LEVEL_HI:0] : glob_stage_q;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    // Routing control, stored whole
    always @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            routing_q <= `DVR_ROUTING_RST;
        end else if (CE_I) begin
            if (clear_now) begin
                routing_q <= `DVR_ROUTING_RST;
            end else if (wr_routing) begin
                routing_q <= wr_data;
            end
        end
    end

    // Audio format control, stored whole
    always @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            format_q <= `DVR_FORMAT_RST;
        end else if (CE_I) begin
            if (clear_now) begin
                format_q <= `DVR_FORMAT_RST;
            end else if (wr_format) begin
                format_q <= wr_data;
            end
        end
    end

    // De-emphasis and mute control, stored whole
    always @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            deemph_q <= `DVR_DEEMPH_MUTE_RST;
        end else if (CE_I) begin
            if (clear_now) begin
                deemph_q <= `DVR_DEEMPH_MUTE_RST;
            end else if (wr_deemph) begin
                deemph_q <= wr_data;
            end
        end
    end

    // Interface and power; unused bits masked so a careless host cannot set them
    always @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            if_power_q <= `DVR_IF_POWER_RST;
        end else if (CE_I) begin
            if (clear_now) begin
                if_power_q <= `DVR_IF_POWER_RST;
            end else if (wr_if_power) begin
                if_power_q <= wr_data & `DVR_IF_POWER_MASK;
            end
        end
    end

    // Mute pin decode; only one live bit
    always @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            mute_pin_q <= `DVR_MUTE_PIN_RST;
        end else if (CE_I) begin
            if (clear_now) begin
                mute_pin_q <= `DVR_MUTE_PIN_RST;
            end else if (wr_mute_pin) begin
                mute_pin_q <= wr_data & `DVR_MUTE_PIN_MASK;
            end
        end
    end

    // Channel 4 control; top three bits unused
    always @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ch4_ctrl_q <= `DVR_CH4_CTRL_RST;
        end else if (CE_I) begin
            if (clear_now) begin
                ch4_ctrl_q <= `DVR_CH4_CTRL_RST;
            end else if (wr_ch4_ctrl) begin
                ch4_ctrl_q <= wr_data & `DVR_CH4_CTRL_MASK;
            end
        end
    end

    // ----------------------------------------------------------------
    // Soft reset state
    // ----------------------------------------------------------------
    always @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            swrst_cnt_q  <= 2'd0;
            swrst_busy_q <= 1'b0;
        end else if (CE_I) begin
            swrst_cnt_q  <= swrst_cnt_d;
            swrst_busy_q <= (swrst_cnt_d != 2'd0);
        end
    end

    // ----------------------------------------------------------------
    // Per-channel decoders
    // ----------------------------------------------------------------
    // Registered so outputs stay glitch-free; they trail the latches by one cycle
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_dec
            dvr_atten_dec u_dec (
                .clk_i    (CLK_SYS_I),
                .rst_n_i  (RST_N_I),
                .ce_i     (CE_I),
                .code_i   (applied_q[g]),
                .mute_o   (ATTEN_MUTE_O[g]),
                .halfdb_o (ATTEN_HALFDB_O[8*g+7:8*g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign LEFT_LEVEL_CH1_O   = applied_q[0];
    assign RIGHT_LEVEL_CH1_O  = applied_q[1];
    assign LEFT_LEVEL_CH2_O   = applied_q[2];
    assign RIGHT_LEVEL_CH2_O  = applied_q[3];
    assign LEFT_LEVEL_CH3_O   = applied_q[4];
    assign RIGHT_LEVEL_CH3_O  = applied_q[5];
    assign LEFT_LEVEL_CH4_O   = applied_q[6];
    assign RIGHT_LEVEL_CH4_O  = applied_q[7];
    assign GLOBAL_LEVEL_O     = glob_applied_q;
    assign ROUTING_CTRL_O     = routing_q;
    assign FORMAT_CTRL_O      = format_q;
    assign DEEMPH_MUTE_CTRL_O = deemph_q;
    assign IF_POWER_CTRL_O    = if_power_q;
    assign MUTE_PIN_CTRL_O    = mute_pin_q;
    assign CH4_CTRL_O         = ch4_ctrl_q;
    assign SW_RESET_O         = swrst_busy_q;

endmodule

// File: inc/dvr_map.vh
// Register map, field positions, reset values and timing counts for the volume register bank
// Overview of operation
// - Eight channels each hold an 8-bit attenuation code, 0.5 dB per step, default FF.
// - Code 00 mutes, 01 is -127.5 dB, 02 is -126.5 dB, each step up from 02 is 0.5 dB less, FF is 0 dB.
// - A volume write with bit 8 clear only loads that channel's staging latch.
// - A volume write with bit 8 set loads it and commits all staging latches together.
// - Master register at 0001000 loads every channel at once, same coding and update bit.
// - Channel 4 sits at 0001101/0001110; channels 1-3 at 00/01, 04/05, 06/07.
// - A write to address 11111 returns every register bit to its default.
// - Software reset lasts two clock periods or until the next control word arrives.
`ifndef DVR_MAP_VH
`define DVR_MAP_VH

// ----------------------------------------------------------------
// Control word layout
// ----------------------------------------------------------------
`define DVR_ADDR_HI      15
`define DVR_ADDR_LO      9
`define DVR_DATA_HI      8
`define DVR_UPDATE_BIT   8
`define DVR_LEVEL_HI     7

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define DVR_LEFT_ATTEN_CH1_ADR    7'h00
`define DVR_RIGHT_ATTEN_CH1_ADR   7'h01
`define DVR_ROUTING_CTRL_ADR      7'h02
`define DVR_FORMAT_CTRL_ADR       7'h03
`define DVR_LEFT_ATTEN_CH2_ADR    7'h04
`define DVR_RIGHT_ATTEN_CH2_ADR   7'h05
`define DVR_LEFT_ATTEN_CH3_ADR    7'h06
`define DVR_RIGHT_ATTEN_CH3_ADR   7'h07
`define DVR_MASTER_ATTEN_ADR      7'h08
`define DVR_DEEMPH_MUTE_ADR       7'h09
`define DVR_IF_POWER_ADR          7'h0A
`define DVR_MUTE_PIN_ADR          7'h0C
`define DVR_LEFT_ATTEN_CH4_ADR    7'h0D
`define DVR_RIGHT_ATTEN_CH4_ADR   7'h0E
`define DVR_CH4_CTRL_ADR          7'h0F
`define DVR_SOFT_RESET_ADR        7'h1F

// ----------------------------------------------------------------
// Reset values and writable-bit masks
// ----------------------------------------------------------------
`define DVR_LEVEL_RST          8'hFF
`define DVR_ROUTING_RST        9'h120
`define DVR_FORMAT_RST         9'h000
`define DVR_DEEMPH_MUTE_RST    9'h000
`define DVR_IF_POWER_RST       9'h080
`define DVR_MUTE_PIN_RST       9'h000
`define DVR_CH4_CTRL_RST       9'h000
`define DVR_IF_POWER_MASK      9'h1FE
`define DVR_MUTE_PIN_MASK      9'h040
`define DVR_CH4_CTRL_MASK      9'h03F

// ----------------------------------------------------------------
// Timing and decode constants
// ----------------------------------------------------------------
`define DVR_SWRST_PERIODS      2
`define DVR_SWRST_CYCLES       2'd2
`define DVR_CODE_MUTE          8'h00
`define DVR_CODE_FLOOR         8'h01
`define DVR_FLOOR_HALFDB       8'hFF

`endif

// File: core/dvr_atten_dec.v
// Registered attenuation code decoder: mute flag and attenuation in half-decibel steps
`timescale 1ns/100ps

module dvr_atten_dec (
    input  wire       clk_i,
    input  wire       rst_n_i,
    input  wire       ce_i,
    input  wire [7:0] code_i,
    output reg        mute_o,
    output reg  [7:0] halfdb_o
);
`include "dvr_map.vh"

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    // Code 01 is pinned to the deepest step so the bottom of the range reads -127.5 dB
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mute_o   <= 1'b0;
            halfdb_o <= 8'h00;
        end else if (ce_i) begin
            mute_o <= (code_i == `DVR_CODE_MUTE);
            if (code_i == `DVR_CODE_FLOOR) begin
                halfdb_o <= `DVR_FLOOR_HALFDB;
            end else if (code_i == `DVR_CODE_MUTE) begin
                halfdb_o <= `DVR_FLOOR_HALFDB;
            end else begin
                halfdb_o <= 8'hFF - code_i;
            end
        end
    end

endmodule

// File: testbench/dvr_host_model.sv
// Host controller model that issues control words to the volume register bank
`timescale 1ns/100ps

module dvr_host_model (
    input  wire        clk_i,
    output logic       wr_o,
    output logic [15:0] word_o
);
    // ------------------------------------------------------------
    // Word issue
    // ------------------------------------------------------------
    initial begin
        wr_o   = 1'b0;
        word_o = 16'h0000;
    end

    // Present one word just after an edge; caller keeps reserved bits zero
    task automatic put(input logic [6:0] adr, input logic [8:0] dat);
        @(posedge clk_i);
        #1;
        wr_o   = 1'b1;
        word_o = {adr, dat};
    endtask

    // Release: the bus shows the inverse so stale data is never mistaken
    task automatic idle();
        @(posedge clk_i);
        #1;
        wr_o   = 1'b0;
        word_o = ~word_o;
    endtask
endmodule

// File: testbench/dvr_bank_sva.sv
// Concurrent checks on the volume register bank ports
`timescale 1ns/100ps

module dvr_bank_sva (
    input wire        CLK_SYS_I,
    input wire        RST_N_I,
    input wire        CE_I,
    input wire        CTRL_WR_I,
    input wire [15:0] CTRL_WORD_I,
    input wire [7:0]  LEFT_LEVEL_CH1_O,
    input wire [7:0]  RIGHT_LEVEL_CH4_O,
    input wire [7:0]  GLOBAL_LEVEL_O,
    input wire [7:0]  ATTEN_MUTE_O,
    input wire [63:0] ATTEN_HALFDB_O,
    input wire [8:0]  ROUTING_CTRL_O,
    input wire        SW_RESET_O
);
    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    wire       wr  = CE_I && CTRL_WR_I;
    wire [6:0] adr = CTRL_WORD_I[15:9];
    wire       upd = CTRL_WORD_I[8];
    wire [7:0] dat = CTRL_WORD_I[7:0];
    wire       idl = CE_I && !CTRL_WR_I;
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);

    sequence s_rst;
        wr && adr == 7'h1F;
    endsequence
    sequence s_idle2;
        idl [*2];
    endsequence

    property p_stage; wr && adr == 7'h00 && !upd |=> $stable(LEFT_LEVEL_CH1_O); endproperty
    property p_commit; wr && adr == 7'h00 && upd |=> LEFT_LEVEL_CH1_O == $past(dat); endproperty
    property p_master;
        wr && adr == 7'h08 && upd |=> GLOBAL_LEVEL_O == $past(dat) && RIGHT_LEVEL_CH4_O == $past(dat);
    endproperty
    property p_unmap; wr && adr == 7'h0B |=> $stable(ROUTING_CTRL_O) && $stable(GLOBAL_LEVEL_O); endproperty
    property p_mute; CE_I |=> ATTEN_MUTE_O[0] == ($past(LEFT_LEVEL_CH1_O) == 8'h00); endproperty
    property p_halfdb;
        CE_I |=> ATTEN_HALFDB_O[7:0] ==
            (($past(LEFT_LEVEL_CH1_O) < 8'h02) ? 8'hFF : 8'hFF - $past(LEFT_LEVEL_CH1_O));
    endproperty
    property p_sr_set;
        s_rst |=> SW_RESET_O && ROUTING_CTRL_O == 9'h120 && LEFT_LEVEL_CH1_O == 8'hFF;
    endproperty
    property p_sr_hold; s_rst ##1 idl |=> SW_RESET_O; endproperty
    property p_sr_end; s_rst ##1 s_idle2 |=> !SW_RESET_O; endproperty
    property p_sr_cut; s_rst ##1 (wr && adr != 7'h1F) |=> !SW_RESET_O; endproperty

    a_stage: assert property (p_stage) else $error("staged write moved output");
    a_commit: assert property (p_commit) else $error("update write not applied");
    a_master: assert property (p_master) else $error("master write not applied");
    a_unmap: assert property (p_unmap) else $error("unmapped write had effect");
    a_mute: assert property (p_mute) else $error("mute flag wrong");
    a_halfdb: assert property (p_halfdb) else $error("half dB value wrong");
    a_sr_set: assert property (p_sr_set) else $error("soft reset not applied");
    a_sr_hold: assert property (p_sr_hold) else $error("soft reset too short");
    a_sr_end: assert property (p_sr_end) else $error("soft reset too long");
    a_sr_cut: assert property (p_sr_cut) else $error("write did not end soft reset");
endmodule

bind dvr_bank dvr_bank_sva u_sva (
    .CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .CE_I(CE_I), .CTRL_WR_I(CTRL_WR_I),
    .CTRL_WORD_I(CTRL_WORD_I), .LEFT_LEVEL_CH1_O(LEFT_LEVEL_CH1_O), .RIGHT_LEVEL_CH4_O(RIGHT_LEVEL_CH4_O),
    .GLOBAL_LEVEL_O(GLOBAL_LEVEL_O), .ATTEN_MUTE_O(ATTEN_MUTE_O), .ATTEN_HALFDB_O(ATTEN_HALFDB_O),
    .ROUTING_CTRL_O(ROUTING_CTRL_O), .SW_RESET_O(SW_RESET_O)
);

// File: testbench/tb.sv
// Self-checking bench for the volume register bank
`timescale 1ns/100ps

module tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        ce = 1'b1;
    wire         wr;
    wire  [15:0] word;
    wire  [7:0]  l1, r1, l2, r2, l3, r3, l4, r4, glob, mute;
    wire  [63:0] hdb;
    wire  [8:0]  rc, fc, dc, pc, mc, c4;
    wire         swr;
    int          n_errors = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    // Default control bundle: sw, global, routing, format, deemph, power, mute pin, ch4
    localparam logic [63:0] CR0 = {2'b00, 8'hFF, 9'h120, 9'h000, 9'h000, 9'h080, 9'h000, 9'h000};
    wire  [63:0] lv = {r4, l4, r3, l3, r2, l2, r1, l1};
    wire  [63:0] cr = {1'b0, swr, glob, rc, fc, dc, pc, mc, c4};
    logic [6:0]  adrs [8] = '{7'h00, 7'h01, 7'h04, 7'h05, 7'h06, 7'h07, 7'h0D, 7'h0E};
    logic [7:0]  vals [8] = '{8'h00, 8'h01, 8'h02, 8'h7F, 8'h80, 8'hFE, 8'hC3, 8'h40};

    // ------------------------------------------------------------
    // Clock, reset, watchdog
    // ------------------------------------------------------------
    initial begin
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
    end
    // Generous ceiling: the sequence needs well under 200 cycles
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc > 2000) begin
            n_errors = n_errors + 1;
            stop_test();
        end
    end

    dvr_host_model u_host (.clk_i(clk), .wr_o(wr), .word_o(word));
    dvr_bank #(.CHANNELS(8)) u_dut (
        .CLK_SYS_I(clk), .RST_N_I(rst_n), .CE_I(ce), .CTRL_WR_I(wr), .CTRL_WORD_I(word),
        .LEFT_LEVEL_CH1_O(l1), .RIGHT_LEVEL_CH1_O(r1), .LEFT_LEVEL_CH2_O(l2), .RIGHT_LEVEL_CH2_O(r2),
        .LEFT_LEVEL_CH3_O(l3), .RIGHT_LEVEL_CH3_O(r3), .LEFT_LEVEL_CH4_O(l4), .RIGHT_LEVEL_CH4_O(r4),
        .GLOBAL_LEVEL_O(glob), .ATTEN_MUTE_O(mute), .ATTEN_HALFDB_O(hdb), .ROUTING_CTRL_O(rc),
        .FORMAT_CTRL_O(fc), .DEEMPH_MUTE_CTRL_O(dc), .IF_POWER_CTRL_O(pc), .MUTE_PIN_CTRL_O(mc),
        .CH4_CTRL_O(c4), .SW_RESET_O(swr)
    );

    // ------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------
    task automatic wr1(input logic [6:0] a, input logic [8:0] d);
        u_host.put(a, d);
        u_host.idle();
    endtask
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        @(posedge rst_n);
        chk(lv, {8{8'hFF}});
        chk(cr, CR0);
        // Control registers, then an unmapped address that must change nothing
        wr1(7'h02, 9'h0A5);
        wr1(7'h03, 9'h15A);
        wr1(7'h09, 9'h1C3);
        wr1(7'h0A, 9'h17E);
        wr1(7'h0C, 9'h040);
        wr1(7'h0F, 9'h03F);
        wr1(7'h0B, 9'h1FF);
        chk(cr, {2'b00, 8'hFF, 9'h0A5, 9'h15A, 9'h1C3, 9'h17E, 9'h040, 9'h03F});
        // Stage seven channels back to back, outputs must not move
        for (int i = 0; i < 7; i++) u_host.put(adrs[i], {1'b0, vals[i]});
        u_host.idle();
        chk(lv, {8{8'hFF}});
        wr1(adrs[7], {1'b1, vals[7]});
        chk(lv, {8'h40, 8'hC3, 8'hFE, 8'h80, 8'h7F, 8'h02, 8'h01, 8'h00});
        tick();
        chk(hdb, {8'hBF, 8'h3C, 8'h01, 8'h7F, 8'h80, 8'hFD, 8'hFF, 8'hFF});
        chk({56'h0, mute}, 64'h01);
        // Master with update, then master staged and committed by channel write
        wr1(7'h08, 9'h110);
        chk(lv, {8{8'h10}});
        wr1(7'h08, 9'h030);
        chk(lv, {8{8'h10}});
        wr1(7'h00, 9'h150);
        chk(lv, {{7{8'h30}}, 8'h50});
        chk({56'h0, glob}, 64'h30);
        // Clock enable low: the word is ignored
        tick();
        ce = 1'b0;
        wr1(7'h00, 9'h1AA);
        ce = 1'b1;
        chk(lv, {{7{8'h30}}, 8'h50});
        // Soft reset runs two cycles when left alone
        wr1(7'h1F, 9'h000);
        chk(cr, CR0 | {1'b0, 1'b1, 62'h0});
        chk(lv, {8{8'hFF}});
        tick();
        chk({63'h0, swr}, 64'h1);
        tick();
        chk({63'h0, swr}, 64'h0);
        // A write right after it ends the hold and is applied
        u_host.put(7'h1F, 9'h000);
        u_host.put(7'h08, 9'h120);
        u_host.idle();
        chk({63'h0, swr}, 64'h0);
        chk({56'h0, glob}, 64'h20);
        // One more edge so the cut-hold check sees its consequent
        tick();
        chk({63'h0, swr}, 64'h0);
        chk(lv, {8{8'h20}});
        stop_test();
    end
endmodule
